// >>> rtl/cfms_map.vh
// register offsets, field layout and reset values of the filter mask select block
`ifndef CFMS_MAP_VH
`define CFMS_MAP_VH
`define CFMS_SEL_OFFSET 12'h000
`define CFMS_SEL_RESET 16'h0000
`define CFMS_FIELD_W 2
`define CFMS_FIRST_FILTER 8
`define CFMS_NUM_FILTERS 8
`define CFMS_SRC_MASK0 2'h0
`define CFMS_SRC_MASK1 2'h1
`define CFMS_SRC_MASK2 2'h2
`define CFMS_SRC_RSVD 2'h3
`endif

// >>> rtl/cfms_filter_mask_select_hi.v
// mask source select for acceptance filters 8 to 15, with apb register and mask compare
//
// Overview of operation
// RULE_01: Bits 15-14 hold the filter 15 mask source and filter 15 compares with that mask set.
// RULE_02: Value 10 selects mask set 2, and 11 is reserved and must not be written by software.
// RULE_03: Value 01 selects mask set 1 for the associated filter.
// RULE_04: Value 00 selects mask set 0 for the associated filter.
// RULE_05: Bits 13-12 hold the filter 14 mask source with the same encoding.
// RULE_06: Bits 11-10 hold the filter 13 mask source with the same encoding.
// RULE_07: Bits 9-8 hold the filter 12 mask source with the same encoding.
// RULE_08: Bits 7-6, 5-4, 3-2 and 1-0 hold filters 11, 10, 9 and 8 with the same encoding.
// RULE_09: A mask bit of one includes the identifier bit in the compare, zero makes it don't-care.
// RULE_10: All fields are read/write and reset to zero so every filter starts on mask 0.
//
// The address map and the APB interface to the registers were decided locally.
`include "cfms_map.vh"

module cfms_filter_mask_select_hi #(
  parameter ID_W = 29
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [ID_W-1:0] mask0,
  input wire [ID_W-1:0] mask1,
  input wire [ID_W-1:0] mask2,
  input wire [ID_W*8-1:0] filter_ids,
  input wire [ID_W-1:0] msg_id,
  output reg [7:0] filter_hit,
  output reg [15:0] selected_mask_source
);

  // the select register: eight two-bit mask source fields, filter 8 in the lowest pair
  reg [15:0] filter_mask_select_hi;
  // hit vector from the compare, registered into filter_hit
  reg [7:0] next_hit;
  // next values of the apb answer, registered so the bus sees flip-flop outputs
  reg next_pready;
  reg next_pslverr;
  reg [31:0] next_prdata;
  // next value of the select register after a completed write
  reg [15:0] next_select;

  // register word address as a full-width constant, so the decode compares equal widths
  wire [11:0] sel_base = `CFMS_SEL_OFFSET;

  // picks the mask set named by a two-bit source field; reserved value gives an all-zero mask
  function [ID_W-1:0] pick_mask;
    input [1:0] src;
    input [ID_W-1:0] m0;
    input [ID_W-1:0] m1;
    input [ID_W-1:0] m2;
    begin
      case (src)
        // RULE_04: zero picks mask0
        `CFMS_SRC_MASK0: pick_mask = m0;
        // RULE_03: one picks mask1
        `CFMS_SRC_MASK1: pick_mask = m1;
        // RULE_02: two picks mask2
        `CFMS_SRC_MASK2: pick_mask = m2;
        default: pick_mask = {ID_W{1'b0}};
      endcase
    end
  endfunction

  // masked equality: only identifier bits whose mask bit is one take part
  function masked_equal;
    input [ID_W-1:0] a;
    input [ID_W-1:0] b;
    input [ID_W-1:0] m;
    begin
      // RULE_09: mask one compares, zero ignores
      masked_equal = (((a ^ b) & m) == {ID_W{1'b0}});
    end
  endfunction

  // one filter's verdict; a reserved source never matches, so a stray 11 fails safe
  function filter_match;
    input [1:0] src;
    input [ID_W-1:0] fid;
    input [ID_W-1:0] id;
    input [ID_W-1:0] m0;
    input [ID_W-1:0] m1;
    input [ID_W-1:0] m2;
    begin
      // RULE_02: reserved code gives no hit
      filter_match = (src != `CFMS_SRC_RSVD) &&
        masked_equal(fid, id, pick_mask(src, m0, m1, m2));
    end
  endfunction

  // byte-lane merge: lane 0 carries bits 7:0 and lane 1 bits 15:8; lanes 2 and 3 hold nothing
  function [15:0] merge_lanes;
    input [15:0] old;
    input [15:0] wdata;
    input [1:0] strb;
    begin
      merge_lanes = old;
      if (strb[0]) begin
        merge_lanes[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
        merge_lanes[15:8] = wdata[15:8];
      end
    end
  endfunction

  // apb phases: the slave answers one edge after setup, so the access phase has one cycle
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready;
  // low two address bits are ignored: the register is one aligned word
  wire sel_hit = (paddr[11:2] == sel_base[11:2]);

  // field wires; the compare reads these so each field has one named home
  // RULE_01: filter 15 field
  wire [1:0] filter15_mask_source = filter_mask_select_hi[15:14];
  // RULE_05: filter 14 field
  wire [1:0] filter14_mask_source = filter_mask_select_hi[13:12];
  // RULE_06: filter 13 field
  wire [1:0] filter13_mask_source = filter_mask_select_hi[11:10];
  // RULE_07: filter 12 field
  wire [1:0] filter12_mask_source = filter_mask_select_hi[9:8];
  // RULE_08: filters 11 to 8 fields
  wire [1:0] filter11_mask_source = filter_mask_select_hi[7:6];
  wire [1:0] filter10_mask_source = filter_mask_select_hi[5:4];
  wire [1:0] filter9_mask_source = filter_mask_select_hi[3:2];
  wire [1:0] filter8_mask_source = filter_mask_select_hi[1:0];

  // filter identifiers, filter 8 in the lowest slice of the packed bus
  wire [ID_W-1:0] filter8_id = filter_ids[0 +: ID_W];
  wire [ID_W-1:0] filter9_id = filter_ids[ID_W +: ID_W];
  wire [ID_W-1:0] filter10_id = filter_ids[2*ID_W +: ID_W];
  wire [ID_W-1:0] filter11_id = filter_ids[3*ID_W +: ID_W];
  wire [ID_W-1:0] filter12_id = filter_ids[4*ID_W +: ID_W];
  wire [ID_W-1:0] filter13_id = filter_ids[5*ID_W +: ID_W];
  wire [ID_W-1:0] filter14_id = filter_ids[6*ID_W +: ID_W];
  wire [ID_W-1:0] filter15_id = filter_ids[7*ID_W +: ID_W];

  // per-filter masked compare; bit k of the hit vector belongs to filter 8+k
  always @* begin
    next_hit = 8'h00;
    next_hit[0] = filter_match(filter8_mask_source, filter8_id, msg_id, mask0, mask1, mask2);
    next_hit[1] = filter_match(filter9_mask_source, filter9_id, msg_id, mask0, mask1, mask2);
    next_hit[2] = filter_match(filter10_mask_source, filter10_id, msg_id, mask0, mask1, mask2);
    next_hit[3] = filter_match(filter11_mask_source, filter11_id, msg_id, mask0, mask1, mask2);
    next_hit[4] = filter_match(filter12_mask_source, filter12_id, msg_id, mask0, mask1, mask2);
    next_hit[5] = filter_match(filter13_mask_source, filter13_id, msg_id, mask0, mask1, mask2);
    next_hit[6] = filter_match(filter14_mask_source, filter14_id, msg_id, mask0, mask1, mask2);
    next_hit[7] = filter_match(filter15_mask_source, filter15_id, msg_id, mask0, mask1, mask2);
  end

  // apb answer: ready for one cycle after setup, error for any other word address
  always @* begin
    next_pready = apb_setup;
    next_pslverr = apb_setup & ~sel_hit;
    next_prdata = 32'h00000000;
    // read data stands only while pready is high, zero otherwise
    if (apb_setup & ~pwrite & sel_hit) begin
      next_prdata = {16'h0000, filter_mask_select_hi};
    end
  end

  // a write lands only at the edge that completes the access phase
  always @* begin
    next_select = filter_mask_select_hi;
    if (apb_done & pwrite & sel_hit) begin
      next_select = merge_lanes(filter_mask_select_hi, pwdata[15:0], pstrb[1:0]);
    end
  end

  // apb answer registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // RULE_10: fields clear at reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_mask_select_hi <= `CFMS_SEL_RESET;
    end else begin
      filter_mask_select_hi <= next_select;
    end
  end

  // outputs registered so downstream logic sees glitch-free values; one cycle of latency
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_hit <= 8'h00;
      selected_mask_source <= `CFMS_SEL_RESET;
    end else begin
      filter_hit <= next_hit;
      selected_mask_source <= filter_mask_select_hi;
    end
  end

endmodule

// >>> verif/cfms_properties.sv
// assertions on the filter mask select ports
module cfms_properties (input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr, input wire [31:0] pwdata, prdata, input wire [7:0] filter_hit,
  input wire [15:0] selected_mask_source, input wire [28:0] mask2, msg_id,
  input wire [231:0] filter_ids);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && !penable |=> pready) else $error("late");
  a_rdy_pulse: assert property (pready |=> !pready) else $error("long");
  a_bad_addr: assert property (psel && !penable && paddr[11:2] != 0 |=> pslverr)
    else $error("err");
  a_wr_copy: assert property (pready && pwrite && !pslverr |=> ##1
    selected_mask_source == $past(pwdata[15:0], 2)) else $error("copy");
  a_rd_back: assert property (pready && !pwrite && !pslverr |->
    prdata == {16'h0, selected_mask_source}) else $error("read");
  a_mask2_hi: assert property (selected_mask_source[15:14] == 2'h2 |-> filter_hit[7] ==
    ((($past(filter_ids[231:203]) ^ $past(msg_id)) & $past(mask2)) == 0)) else $error("m2");
  a_mask2_lo: assert property (selected_mask_source[1:0] == 2'h2 |-> filter_hit[0] ==
    ((($past(filter_ids[28:0]) ^ $past(msg_id)) & $past(mask2)) == 0)) else $error("m2");
  // only a completed write may move the fields
  a_only_wr: assert property ($changed(selected_mask_source) |-> $past(pwrite, 2))
    else $error("chg");
endmodule
bind cfms_filter_mask_select_hi cfms_properties i_cfms_properties (.*);

// >>> verif/cfms_far_end.sv
// far-end model: mask sets and filter identifiers for the compare
module cfms_far_end (output logic [28:0] mask0, mask1, mask2, output logic [231:0] filter_ids);
  timeunit 1ns; timeprecision 1ps;
  // mask 0 exact, mask 1 all don't-care, mask 2 low byte only
  assign {mask0, mask1, mask2} = {{29{1'b1}}, 29'h0, 29'hff};
  assign filter_ids = {8{29'h100}};
endmodule

// >>> verif/cfms_filter_mask_select_hi_tb.sv
// self-checking bench for the filter mask select block
module cfms_filter_mask_select_hi_tb;
  timeunit 1ns; timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic [28:0] mask0, mask1, mask2, msg_id = 0;
  logic [231:0] filter_ids;
  logic [7:0] filter_hit;
  logic [15:0] selected_mask_source;
  int num_errors = 0, n_checks = 0, k, i;
  // rows: register value, then the hits it gives
  // rows never program the reserved code 11
  logic [23:0] rows[4] = '{24'h242422, 24'h8421a5, 24'h699696, 24'ha050cc};
  always #20 pclk = ~pclk;
  cfms_filter_mask_select_hi i_cfms_filter_mask_select_hi (.*);
  cfms_far_end i_cfms_far_end (.*);
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, g);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // apb transfer; idle edge first so no signal is driven twice at once
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) num_errors++;
    if (pready !== 1'b1) finish_test;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 0;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    xfer(0, 12'h000, 0);
    chk("reset value", 0, r);
    msg_id <= 'h100;
    repeat (2) @(posedge pclk);
    chk("reset hits", 8'hff, filter_hit);
    $display("reset test done");
    for (k = 0; k < 4; k++) begin
      xfer(1, 12'h000, rows[k][23:8]);
      msg_id <= k[0] ? 29'h200 : 29'h201;
      xfer(0, 12'h000, 0);
      chk("read back", rows[k][23:8], r);
      repeat (2) @(posedge pclk);
      chk("filter hits", rows[k][7:0], filter_hit);
    end
    xfer(1, 12'h004, 32'hffff);
    chk("unmapped error", 1, e);
    xfer(0, 12'h000, 0);
    chk("unchanged", 16'ha050, r);
    $display("table and address tests done");
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("reset outputs", 0, {filter_hit, selected_mask_source});
    presetn <= 1;
    xfer(0, 12'h000, 0);
    chk("reset again", 0, r);
    $display("mid-run reset test done");
    finish_test;
  end
endmodule
